// >>> dtpc_pkg.sv
// Shared constants, field layouts and types of the dual timer block.
package dtpc_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_CLKSEL = 8'h04;
  localparam logic [7:0]  OFF_CRA    = 8'h08;
  localparam logic [7:0]  OFF_CRB    = 8'h0c;
  localparam logic [7:0]  OFF_CNT1   = 8'h10;
  localparam logic [7:0]  OFF_CNT2   = 8'h14;
  localparam logic [7:0]  OFF_PEND   = 8'h18;
  localparam logic [7:0]  OFF_IEN    = 8'h1c;
  // Counter and register widths and the special counter values.
  localparam int          CNT_W      = 16;
  localparam int          PRE_W      = 5;
  localparam int          CTRL_W     = 7;
  localparam int          CLKSEL_W   = 11;
  localparam int          PND_W      = 4;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam logic [15:0] CNT_PRESET = 16'hffff;
  localparam logic [4:0]  PRE_ZERO   = 5'h00;
  // Bit positions of the four pending flags and their enables.
  localparam int          PND_A      = 0;
  localparam int          PND_B      = 1;
  localparam int          PND_C      = 2;
  localparam int          PND_D      = 3;
  // Reset values of the software registers.
  localparam logic [6:0]  CTRL_RST   = 7'h00;
  localparam logic [10:0] CLKSEL_RST = 11'h000;
  localparam logic [3:0]  PND_RST    = 4'h0;

  // Operating mode; the code equals the mode number, zero holds both counters.
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_PWM = 2'b01,
    MODE_CAP = 2'b10,
    MODE_TMR = 2'b11
  } dtpc_mode_t;

  // Clock source of one counter.
  typedef enum logic [2:0] {
    CS_NONE = 3'h0,
    CS_PRE  = 3'h1,
    CS_EXT  = 3'h2,
    CS_ACC  = 3'h3,
    CS_SLOW = 3'h4
  } dtpc_csel_t;

  // Control register layout, bit 0 upward: mode, pin functions, edges, level.
  typedef struct packed {
    logic       out_level;
    logic       b_fall;
    logic       a_fall;
    logic       b_fn_en;
    logic       a_fn_en;
    dtpc_mode_t mode;
  } dtpc_ctrl_t;

  // Clock select register layout: sel1 [2:0], sel2 [5:3], prescale [10:6].
  typedef struct packed {
    logic [4:0] prescale;
    dtpc_csel_t sel2;
    dtpc_csel_t sel1;
  } dtpc_clksel_t;
endpackage

// >>> dtpc_pin_sync.sv
// Two-flop synchroniser with a polarity-selected edge detector for one pin.
`timescale 1ns/1ps
module dtpc_pin_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  input  wire logic fall,
  output logic      level,
  output logic      event_p
);
  logic meta;  // First stage, read only by the second stage.
  logic prev;  // Last synchronised level for edge detection.

  // Synchronise the pin and keep one older sample.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta  <= 1'b0;
      level <= 1'b0;
      prev  <= 1'b0;
    end else begin
      meta  <= pin;
      level <= meta;
      prev  <= level;
    end
  end

  // One-cycle pulse on the selected transition.
  assign event_p = fall ? (prev & ~level) : (~prev & level);
endmodule

// >>> dtpc_timer.sv
// Dual 16-bit timer with PWM, dual capture and dual timer modes behind APB.
`timescale 1ns/1ps
// What this block does
// - PWM mode reloads alternate A then B.
// - PWM first reload from A after entry.
// - Stopping counter one restarts alternation at A.
// - Enabled counter counts from its current value.
// - PWM underflow toggles pin A when enabled.
// - Software picks initial pin A level.
// - PWM reloads set flag A or B.
// - PWM mode counter two underflow flags D.
// - Pin B events count preloaded counter two.
// - Capture mode copies counter one on edges.
// - Preset stores value then sets FFFF.
// - Each capture input picks rising or falling.
// - Capture mode flags A, B, C separately.
// - Capture mode counter two is system timer.
// - Capture mode stops counter one on pin clocks.
// - Timer mode counter one reloads A, flags A.
// - Timer mode counter two reloads B, flags D.
// - Pin B or prescaler clocks either counter.
// - Counters are 16-bit, underflow 0000 to FFFF.
// - Each counter has its own clock selector.
// - Output level bit holds pin A level.
module dtpc_timer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pin_a_in,
  output logic             pin_a_out,
  output logic             pin_a_oe,
  input  wire logic        pin_b_in,
  input  wire logic        slow_clk_in,
  output logic             irq_timer1,
  output logic             irq_timer2
);
  dtpc_pkg::dtpc_ctrl_t   ctrl;        // Mode, pin functions and edges.
  dtpc_pkg::dtpc_clksel_t clksel;      // Clock selectors and prescale.
  logic [15:0]            reload_capture_a;  // Reload or capture register A.
  logic [15:0]            reload_capture_b;  // Reload or capture register B.
  logic [15:0]            counter_one;       // First down counter.
  logic [15:0]            counter_two;       // Second down counter.
  logic [3:0]             pend;        // Pending flags A to D.
  logic [3:0]             ien;         // Interrupt enables A to D.
  logic                   pin_a_output_level; // Current PWM level.
  logic                   alt;         // High when the next PWM reload is from B.
  logic [4:0]             pre_cnt;     // Prescaler down counter.
  logic                   pre_tick;    // Prescaled clock pulse.
  logic                   a_ev;        // Valid pin A transition.
  logic                   b_lvl;       // Synchronised pin B level.
  logic                   b_ev;        // Valid pin B transition.
  logic                   slow_ev;     // Slow clock rising edge.
  logic                   wr;          // APB write in its access phase.
  logic                   tick1;       // Counter one steps this cycle.
  logic                   tick2;       // Counter two steps this cycle.
  logic                   preset_hit;  // A capture event presets counter one.
  logic                   uf1;         // Counter one underflows.
  logic                   uf2;         // Counter two underflows.
  logic                   in_pwm;      // Mode one active.
  logic                   in_cap;      // Mode two active.
  logic                   in_tmr;      // Mode three active.
  logic [3:0]             pend_set;    // Hardware flag events.
  logic [3:0]             pend_clr;    // Software write-one-to-clear.
  // True when the current access is a write to the given offset.
  function automatic logic wr_hit(input logic [7:0] off);
    wr_hit = wr && (paddr == off);
  endfunction
  // Clock pulse for one counter from its selector; pin B sources may be barred.
  function automatic logic clk_tick(input dtpc_pkg::dtpc_csel_t sel,
                                    input logic allow_b);
    clk_tick = 1'b0;
    case (sel)
      dtpc_pkg::CS_PRE:  clk_tick = pre_tick;
      dtpc_pkg::CS_EXT:  clk_tick = allow_b && b_ev;
      // Accumulate while pin B sits at the level after its active edge.
      dtpc_pkg::CS_ACC:  clk_tick = allow_b && pre_tick && (b_lvl ^ ctrl.b_fall);
      dtpc_pkg::CS_SLOW: clk_tick = slow_ev;
      default:           clk_tick = 1'b0;
    endcase
  endfunction
  // Read data for an offset; unmapped offsets read zero.
  function automatic logic [31:0] rd_mux(input logic [7:0] off);
    if (off == dtpc_pkg::OFF_CTRL) begin
      rd_mux = {25'h0000000, pin_a_output_level, ctrl[5:0]};
    end else if (off == dtpc_pkg::OFF_CLKSEL) begin
      rd_mux = {21'h000000, clksel};
    end else if (off == dtpc_pkg::OFF_CRA) begin
      rd_mux = {16'h0000, reload_capture_a};
    end else if (off == dtpc_pkg::OFF_CRB) begin
      rd_mux = {16'h0000, reload_capture_b};
    end else if (off == dtpc_pkg::OFF_CNT1) begin
      rd_mux = {16'h0000, counter_one};
    end else if (off == dtpc_pkg::OFF_CNT2) begin
      rd_mux = {16'h0000, counter_two};
    end else if (off == dtpc_pkg::OFF_PEND) begin
      rd_mux = {28'h0000000, pend};
    end else if (off == dtpc_pkg::OFF_IEN) begin
      rd_mux = {28'h0000000, ien};
    end else begin
      rd_mux = 32'h00000000;
    end
  endfunction
  // True for every offset that holds a register.
  function automatic logic mapped(input logic [7:0] off);
    mapped = (off[1:0] == 2'b00) && (off <= dtpc_pkg::OFF_IEN);
  endfunction
  // Pin A capture input, edge chosen by software.
  // per-pin edge select
  dtpc_pin_sync u_sync_a (
    .clk     (clk),
    .rst     (rst),
    .pin     (pin_a_in),
    .fall    (ctrl.a_fall),
    .level   (),
    .event_p (a_ev)
  );
  // Pin B capture or event input.
  dtpc_pin_sync u_sync_b (
    .clk     (clk),
    .rst     (rst),
    .pin     (pin_b_in),
    .fall    (ctrl.b_fall),
    .level   (b_lvl),
    .event_p (b_ev)
  );
  // Slow clock, counted on its rising edge.
  dtpc_pin_sync u_sync_slow (
    .clk     (clk),
    .rst     (rst),
    .pin     (slow_clk_in),
    .fall    (1'b0),
    .level   (),
    .event_p (slow_ev)
  );
  // Mode decode and bus strobes.
  // mode field decode
  assign in_pwm  = (ctrl.mode == dtpc_pkg::MODE_PWM);
  assign in_cap  = (ctrl.mode == dtpc_pkg::MODE_CAP);
  assign in_tmr  = (ctrl.mode == dtpc_pkg::MODE_TMR);
  assign wr      = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  // Register the read data in the setup phase so it is a flop output.
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux(paddr);
    end
  end
  // Control and clock select registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl   <= dtpc_pkg::CTRL_RST;
      clksel <= dtpc_pkg::CLKSEL_RST;
    end else begin
      if (wr_hit(dtpc_pkg::OFF_CTRL)) begin
        ctrl <= pwdata[dtpc_pkg::CTRL_W-1:0];
      end
      if (wr_hit(dtpc_pkg::OFF_CLKSEL)) begin
        clksel <= pwdata[dtpc_pkg::CLKSEL_W-1:0];
      end
    end
  end
  // Prescaler: divides the system clock by prescale plus one.
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_cnt <= dtpc_pkg::PRE_ZERO;
    end else if (pre_cnt == dtpc_pkg::PRE_ZERO) begin
      pre_cnt <= clksel.prescale;
    end else begin
      pre_cnt <= pre_cnt - 5'h01;
    end
  end
  assign pre_tick = (pre_cnt == dtpc_pkg::PRE_ZERO);
  // Counter clocks; mode zero holds both counters.
  // independent clock selectors
  // pin B clocks barred for counter one in capture
  // pin B or prescaler for either counter
  assign tick1 = (ctrl.mode != dtpc_pkg::MODE_OFF) && clk_tick(clksel.sel1, !in_cap);
  assign tick2 = (ctrl.mode != dtpc_pkg::MODE_OFF) && clk_tick(clksel.sel2, 1'b1);
  assign preset_hit = in_cap && ((a_ev && ctrl.a_fn_en) || (b_ev && ctrl.b_fn_en));
  assign uf1 = tick1 && (counter_one == dtpc_pkg::CNT_ZERO) &&
               !wr_hit(dtpc_pkg::OFF_CNT1) && !preset_hit;
  assign uf2 = tick2 && (counter_two == dtpc_pkg::CNT_ZERO) &&
               !wr_hit(dtpc_pkg::OFF_CNT2);
  // Counter one: software load, capture preset, then counting.
  always_ff @(posedge clk) begin
    if (rst) begin
      counter_one <= dtpc_pkg::CNT_ZERO;
    end else if (wr_hit(dtpc_pkg::OFF_CNT1)) begin
      counter_one <= pwdata[dtpc_pkg::CNT_W-1:0];
    end else if (preset_hit) begin
      counter_one <= dtpc_pkg::CNT_PRESET;
    end else if (uf1) begin
      if (in_pwm) begin
        counter_one <= alt ? reload_capture_b : reload_capture_a;
      end else if (in_tmr) begin
        counter_one <= reload_capture_a;
      end else begin
        counter_one <= dtpc_pkg::CNT_PRESET;
      end
    end else if (tick1) begin
      counter_one <= counter_one - 16'h0001;
    end
  end
  // Counter two: software preload, then counting; reload only in timer mode.
  always_ff @(posedge clk) begin
    if (rst) begin
      counter_two <= dtpc_pkg::CNT_ZERO;
    end else if (wr_hit(dtpc_pkg::OFF_CNT2)) begin
      counter_two <= pwdata[dtpc_pkg::CNT_W-1:0];
    end else if (uf2) begin
      counter_two <= in_tmr ? reload_capture_b : dtpc_pkg::CNT_PRESET;
    end else if (tick2) begin
      counter_two <= counter_two - 16'h0001;
    end
  end
  // Reload source toggle; held at A outside PWM mode or while stopped.
  always_ff @(posedge clk) begin
    if (rst) begin
      alt <= 1'b0;
    end else if (!in_pwm || clksel.sel1 == dtpc_pkg::CS_NONE) begin
      alt <= 1'b0;
    end else if (uf1) begin
      alt <= ~alt;
    end
  end
  // Capture register A: capture has priority over a software write.
  always_ff @(posedge clk) begin
    if (rst) begin
      reload_capture_a <= dtpc_pkg::CNT_ZERO;
    end else if (in_cap && a_ev) begin
      reload_capture_a <= counter_one;
    end else if (wr_hit(dtpc_pkg::OFF_CRA)) begin
      reload_capture_a <= pwdata[dtpc_pkg::CNT_W-1:0];
    end
  end
  // Capture register B: capture has priority over a software write.
  always_ff @(posedge clk) begin
    if (rst) begin
      reload_capture_b <= dtpc_pkg::CNT_ZERO;
    end else if (in_cap && b_ev) begin
      reload_capture_b <= counter_one;
    end else if (wr_hit(dtpc_pkg::OFF_CRB)) begin
      reload_capture_b <= pwdata[dtpc_pkg::CNT_W-1:0];
    end
  end
  // Pin A level: software sets it, underflow toggles it when enabled.
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_a_output_level <= 1'b0;
    end else if (wr_hit(dtpc_pkg::OFF_CTRL)) begin
      pin_a_output_level <= pwdata[dtpc_pkg::CTRL_W-1];
    end else if (uf1 && ctrl.a_fn_en && (in_pwm || in_tmr)) begin
      pin_a_output_level <= ~pin_a_output_level;
    end
  end
  // Drive pin A only while it is a PWM or timer mode output.
  // level bit drives pin
  assign pin_a_out = pin_a_output_level;
  assign pin_a_oe  = ctrl.a_fn_en && (in_pwm || in_tmr);

  // Hardware events that raise each pending flag.
  // PWM reload flags
  always_comb begin
    pend_set        = dtpc_pkg::PND_RST;
    pend_set[dtpc_pkg::PND_A] = (in_pwm && uf1 && !alt) || (in_tmr && uf1) ||
                                (in_cap && a_ev);
    pend_set[dtpc_pkg::PND_B] = (in_pwm && uf1 && alt) || (in_cap && b_ev);
    pend_set[dtpc_pkg::PND_C] = in_cap && uf1;
    pend_set[dtpc_pkg::PND_D] = uf2;
  end
  assign pend_clr = wr_hit(dtpc_pkg::OFF_PEND) ? pwdata[dtpc_pkg::PND_W-1:0]
                                               : dtpc_pkg::PND_RST;

  // Pending flags: write one clears, a new event in the same cycle wins.
  always_ff @(posedge clk) begin
    if (rst) begin
      pend <= dtpc_pkg::PND_RST;
    end else begin
      pend <= (pend & ~pend_clr) | pend_set;
    end
  end

  // Interrupt enable register.
  always_ff @(posedge clk) begin
    if (rst) begin
      ien <= dtpc_pkg::PND_RST;
    end else if (wr_hit(dtpc_pkg::OFF_IEN)) begin
      ien <= pwdata[dtpc_pkg::PND_W-1:0];
    end
  end

  // Sources A to C share interrupt one, D drives interrupt two.
  // enabled flags raise interrupts
  assign irq_timer1 = |(pend[dtpc_pkg::PND_C:dtpc_pkg::PND_A] &
                        ien[dtpc_pkg::PND_C:dtpc_pkg::PND_A]);
  assign irq_timer2 = pend[dtpc_pkg::PND_D] && ien[dtpc_pkg::PND_D];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // A PWM underflow with the reload pointing at A.
  sequence pwm_uf_a_s;
    in_pwm && uf1 && !alt;
  endsequence
  // The counter then holds register A and flag A is up.
  sequence load_a_s;
    (counter_one == $past(reload_capture_a)) && pend[dtpc_pkg::PND_A];
  endsequence

  // Reload alternation points at A after a stop or outside PWM.
  alt_restart_a: assert property (
    (!in_pwm || clksel.sel1 == dtpc_pkg::CS_NONE) |=> !alt)
    else $error("reload alternation did not restart at A");
  pwm_reload_a: assert property (pwm_uf_a_s |=> load_a_s ##0 alt)
    else $error("PWM reload from A missing");
  pwm_toggle_a: assert property (
    in_pwm && uf1 && ctrl.a_fn_en && !wr_hit(dtpc_pkg::OFF_CTRL)
    |=> pin_a_out != $past(pin_a_out))
    else $error("pin A did not toggle on underflow");
  capture_copy_a: assert property (
    in_cap && b_ev |=> reload_capture_b == $past(counter_one))
    else $error("capture B did not copy counter one");
  capture_preset_a: assert property (
    preset_hit && !wr_hit(dtpc_pkg::OFF_CNT1)
    |=> counter_one == dtpc_pkg::CNT_PRESET)
    else $error("counter one not preset after capture");
  capture_stop_a: assert property (
    in_cap && clksel.sel1 == dtpc_pkg::CS_EXT && !preset_hit &&
    !wr_hit(dtpc_pkg::OFF_CNT1) |=> $stable(counter_one))
    else $error("counter one moved on a barred clock");
  timer_two_a: assert property (
    in_tmr && uf2 |=> (counter_two == $past(reload_capture_b)) ##0
    pend[dtpc_pkg::PND_D])
    else $error("counter two timer reload missing");
  timer_irq_a: assert property (
    in_tmr && uf1 && ien[dtpc_pkg::PND_A] && !wr_hit(dtpc_pkg::OFF_IEN)
    |=> irq_timer1)
    else $error("timer interrupt one not raised");
endmodule

// >>> dtpc_pin_model.sv
// External pin model: capture and event pulses on pins A and B, plus a free slow clock.
`timescale 1ns/1ps
module dtpc_pin_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic req_a,
  input  wire logic req_b,
  output logic      pin_a,
  output logic      pin_b,
  output logic      slow_clk
);
  logic [1:0] left_a;  // Cycles of pulse still to show on pin A.
  logic [1:0] left_b;  // Cycles of pulse still to show on pin B.
  logic [2:0] div;     // Divider that makes the slow clock.

  // Each request starts a pulse of two clocks, so the synchroniser cannot miss it.
  // minimum pulse width
  always_ff @(posedge clk) begin
    if (rst) begin
      left_a <= 2'h0;
      left_b <= 2'h0;
    end else begin
      left_a <= req_a ? 2'h2 : left_a - {1'b0, left_a != 2'h0};
      left_b <= req_b ? 2'h2 : left_b - {1'b0, left_b != 2'h0};
    end
  end

  // The slow clock runs free at one sixteenth of the system clock.
  always_ff @(posedge clk) begin
    if (rst) begin
      div      <= 3'h0;
      slow_clk <= 1'b0;
    end else begin
      div <= div + 3'h1;
      if (div == 3'h7) begin
        slow_clk <= ~slow_clk;
      end
    end
  end

  // Pins idle low between pulses.
  assign pin_a = left_a != 2'h0;
  assign pin_b = left_b != 2'h0;
endmodule

// >>> tb_dual_timer_pwm_capture_modes.sv
// Self-checking bench of the dual timer through its APB port and pins.
`timescale 1ns/1ps
module tb_dual_timer_pwm_capture_modes;
  logic        clk = 1'b0;     // System clock, 100 MHz.
  logic        rst = 1'b1;     // Synchronous reset.
  logic        psel = 1'b0;    // APB select.
  logic        penable = 1'b0; // APB enable.
  logic        pwrite = 1'b0;  // APB direction.
  logic [7:0]  paddr = 8'h00;  // APB address.
  logic [31:0] pwdata = 32'h0; // APB write data.
  logic [31:0] prdata;         // APB read data.
  logic        pready;         // APB ready.
  logic        pslverr;        // APB error.
  logic        pin_a;          // Pin A level from the model.
  logic        pin_b;          // Pin B level from the model.
  logic        slow_clk;       // Slow clock from the model.
  logic        pin_a_out;      // PWM level driven on pin A.
  logic        pin_a_oe;       // Pin A driver enable.
  logic        irq_timer1;     // Timer interrupt one.
  logic        irq_timer2;     // Timer interrupt two.
  logic        req_a = 1'b0;   // Pulse request for pin A.
  logic        req_b = 1'b0;   // Pulse request for pin B.
  logic [31:0] rd;             // Last read word.
  logic        er;             // Last error flag.
  int          n;              // Measured toggle spacing.
  int          failures = 0;   // Count of mismatches.
  int          num_checks = 0; // Count of comparisons.

  dtpc_timer DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_a_in(pin_a), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_in(pin_b),
    .slow_clk_in(slow_clk), .irq_timer1(irq_timer1), .irq_timer2(irq_timer2));
  dtpc_pin_model pins (.clk(clk), .rst(rst), .req_a(req_a), .req_b(req_b), .pin_a(pin_a),
    .pin_b(pin_b), .slow_clk(slow_clk));

  // The clock flips every half period.
  always #5 clk = ~clk;

  // One APB transfer: setup, then access held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Compares one result and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Reads a register and compares it.
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Counts clocks until pin A changes level.
  task automatic wait_tog(output int cnt);
    logic was;
    was = pin_a_out;
    cnt = 0;
    do begin
      @(posedge clk);
      #1;
      cnt++;
    end while (pin_a_out === was && cnt < 200);
  endtask

  // Sends one pulse on the chosen pin and lets the capture settle.
  task automatic pulse(input logic on_b);
    @(posedge clk);
    req_a <= ~on_b;
    req_b <= on_b;
    @(posedge clk);
    req_a <= 1'b0;
    req_b <= 1'b0;
    repeat (10) @(posedge clk);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    close_out();
  end

  // Main sequence of tests.
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rchk(dtpc_pkg::OFF_CTRL, 32'h0);
    rchk(dtpc_pkg::OFF_CLKSEL, 32'h0);
    rchk(dtpc_pkg::OFF_PEND, 32'h0);
    rchk(8'h20, 32'h0);
    chk({31'h0, er}, 32'h1);
    // PWM mode with a high start level and alternate reloads.
    apb(1'b1, dtpc_pkg::OFF_CRA, 32'h3);
    apb(1'b1, dtpc_pkg::OFF_CRB, 32'h5);
    apb(1'b1, dtpc_pkg::OFF_CNT1, 32'h2);
    apb(1'b1, dtpc_pkg::OFF_IEN, 32'h1);
    apb(1'b1, dtpc_pkg::OFF_CTRL, 32'h45);
    #1;
    chk({30'h0, pin_a_oe, pin_a_out}, 32'h3);
    apb(1'b1, dtpc_pkg::OFF_CLKSEL, 32'h1);
    wait_tog(n);
    chk({31'h0, pin_a_out}, 32'h0);
    wait_tog(n);
    chk(n, 32'd4);
    wait_tog(n);
    chk(n, 32'd6);
    rchk(dtpc_pkg::OFF_PEND, 32'h3);
    chk({31'h0, irq_timer1}, 32'h1);
    // Run on to just after a reload from A, so the next reload would be from B.
    wait_tog(n);
    wait_tog(n);
    chk(n, 32'd6);
    // Stop and restart: the first reload is from A again.
    apb(1'b1, dtpc_pkg::OFF_CLKSEL, 32'h0);
    apb(1'b1, dtpc_pkg::OFF_PEND, 32'hf);
    apb(1'b1, dtpc_pkg::OFF_CLKSEL, 32'h1);
    wait_tog(n);
    rchk(dtpc_pkg::OFF_PEND, 32'h1);
    // Counter two counts pin B events in PWM mode; preload one needs two events.
    apb(1'b1, dtpc_pkg::OFF_CNT2, 32'h1);
    apb(1'b1, dtpc_pkg::OFF_PEND, 32'h8);
    apb(1'b1, dtpc_pkg::OFF_CLKSEL, 32'h11);
    pulse(1'b1);
    apb(1'b0, dtpc_pkg::OFF_PEND, 32'h0);
    chk(rd & 32'h8, 32'h0);
    pulse(1'b1);
    apb(1'b0, dtpc_pkg::OFF_PEND, 32'h0);
    chk(rd & 32'h8, 32'h8);
    // Dual capture with a stopped time base, preset on A, falling edge on B.
    apb(1'b1, dtpc_pkg::OFF_CLKSEL, 32'h0);
    apb(1'b1, dtpc_pkg::OFF_CTRL, 32'h26);
    apb(1'b1, dtpc_pkg::OFF_CNT1, 32'h1234);
    apb(1'b1, dtpc_pkg::OFF_PEND, 32'hf);
    pulse(1'b0);
    rchk(dtpc_pkg::OFF_CRA, 32'h1234);
    rchk(dtpc_pkg::OFF_CNT1, 32'hffff);
    pulse(1'b1);
    rchk(dtpc_pkg::OFF_CRB, 32'hffff);
    rchk(dtpc_pkg::OFF_PEND, 32'h3);
    // Pin B clocking stops counter one in capture mode.
    apb(1'b1, dtpc_pkg::OFF_CLKSEL, 32'h2);
    apb(1'b1, dtpc_pkg::OFF_CNT1, 32'h100);
    pulse(1'b1);
    pulse(1'b1);
    rchk(dtpc_pkg::OFF_CNT1, 32'h100);
    // Both counters on the prescaler: counter one flags C, counter two flags D.
    apb(1'b1, dtpc_pkg::OFF_CNT1, 32'h3);
    apb(1'b1, dtpc_pkg::OFF_CNT2, 32'h1);
    apb(1'b1, dtpc_pkg::OFF_PEND, 32'hf);
    apb(1'b1, dtpc_pkg::OFF_CLKSEL, 32'h9);
    repeat (8) @(posedge clk);
    rchk(dtpc_pkg::OFF_PEND, 32'hc);
    apb(1'b1, dtpc_pkg::OFF_CLKSEL, 32'h0);
    // Dual timer: pin B events clock counter two, which reloads from B.
    apb(1'b1, dtpc_pkg::OFF_CTRL, 32'h3);
    apb(1'b1, dtpc_pkg::OFF_CRB, 32'h9);
    apb(1'b1, dtpc_pkg::OFF_CNT2, 32'h2);
    apb(1'b1, dtpc_pkg::OFF_IEN, 32'h8);
    apb(1'b1, dtpc_pkg::OFF_PEND, 32'hf);
    apb(1'b1, dtpc_pkg::OFF_CLKSEL, 32'h10);
    repeat (3) pulse(1'b1);
    rchk(dtpc_pkg::OFF_CNT2, 32'h9);
    rchk(dtpc_pkg::OFF_PEND, 32'h8);
    chk({31'h0, irq_timer2}, 32'h1);
    // Timer mode on the slow clock: reload one toggles pin A every two slow edges.
    apb(1'b1, dtpc_pkg::OFF_CTRL, 32'h7);
    apb(1'b1, dtpc_pkg::OFF_CRA, 32'h1);
    apb(1'b1, dtpc_pkg::OFF_CNT1, 32'h0);
    apb(1'b1, dtpc_pkg::OFF_CLKSEL, 32'h14);
    wait_tog(n);
    wait_tog(n);
    chk(n, 32'd32);
    rchk(dtpc_pkg::OFF_PEND, 32'h9);
    close_out();
  end
endmodule
